// ### design/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------------------
// configuration space placement
// ----------------------------------------------------------------------------
`define PMC_CAP_PTR_ADDR 8'h34
`define PMC_CAP_BASE_DEFAULT 8'h40
`define PMC_OFS_CAPABILITY_IDENTIFIER 8'h00
`define PMC_OFS_NEXT 8'h01
`define PMC_OFS_CAPS 8'h02
`define PMC_OFS_CTRL_STAT 8'h04
`define PMC_OFS_BRIDGE_EXT 8'h06
`define PMC_OFS_DATA 8'h07

// ----------------------------------------------------------------------------
// fixed values
// ----------------------------------------------------------------------------
`define PMC_CAPABILITY_IDENTIFIER_VALUE 8'h01
`define PMC_NEXT_VALUE 8'h00
`define PMC_AUX_CURRENT_100MA 3'h2
`define PMC_AUX_SELF_POWERED 3'h0
`define PMC_SPEC_REV_1_1 3'h2

// ----------------------------------------------------------------------------
// capabilities word field positions
// ----------------------------------------------------------------------------
`define PMC_BIT_WAKE_D3COLD 15
`define PMC_BIT_WAKE_D3HOT 14
`define PMC_BIT_WAKE_D2 13
`define PMC_BIT_WAKE_D1 12
`define PMC_BIT_WAKE_D0 11
`define PMC_BIT_SECOND_SLEEP 10
`define PMC_BIT_FIRST_SLEEP 9
`define PMC_AUX_HI 8
`define PMC_AUX_LO 6
`define PMC_BIT_DEV_INIT 5
`define PMC_BIT_WAKE_CLOCK 3
`define PMC_REV_HI 2
`define PMC_REV_LO 0

`endif

// ### design/pmc_pkg.sv
package pmc_pkg;

    // ------------------------------------------------------------------------
    // host controller function flavours
    // ------------------------------------------------------------------------
    typedef enum logic {
        PMC_FUNC_OHCI = 1'b0,
        PMC_FUNC_EHCI = 1'b1
    } pmc_func_kind_t;

    // ------------------------------------------------------------------------
    // strap capture phase
    // ------------------------------------------------------------------------
    typedef enum logic {
        PMC_PH_STRAP = 1'b0,
        PMC_PH_RUN = 1'b1
    } pmc_phase_t;

    // ------------------------------------------------------------------------
    // configuration access request and answer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] dword;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } pmc_cfg_req_t;

    typedef struct packed {
        logic done;
        logic [31:0] rdData;
    } pmc_cfg_rsp_t;

endpackage : pmc_pkg

// ### design/pmc_capability.sv
// Operation
// - identifier byte reads 01h, never written
// - only one entry carries identifier 01h
// - next offset byte reads 00h, last entry
// - structure decoded relative to pointer at 34h
// - capabilities word is two bytes, read only
// - bits 15..11 give wake support per state
// - X bits: 0 for OHCI, 1 for EHCI
// - bit 10 set only when D2 supported
// - bit 9 set only when D1 supported
// - bits 2..0 read 010b, revision 1.1
// - bits 8..6 give aux current, 010b=100mA
// - cold wake strap sets bit 15 default
`include "pmc_defines.svh"

module pmc_capability
    import pmc_pkg::*;
#(
    parameter pmc_func_kind_t FUNC_KIND = PMC_FUNC_EHCI,
    parameter logic [7:0] CAP_BASE = `PMC_CAP_BASE_DEFAULT
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic coldWakeStrap,
    input wire pmc_cfg_req_t cfgReq,
    output pmc_cfg_rsp_t cfgRsp
);

    // ------------------------------------------------------------------------
    // derived capability bits
    // ------------------------------------------------------------------------
    localparam logic funcX = (FUNC_KIND == PMC_FUNC_EHCI);
    localparam logic [7:0] ptrAddr = `PMC_CAP_PTR_ADDR;
    localparam logic [5:0] ptrDword = ptrAddr[7:2];
    localparam logic [5:0] baseDword = CAP_BASE[7:2];
    localparam logic [5:0] ctrlDword = 6'(baseDword + 6'h01);

    // assemble the capabilities word around the sampled strap
    function automatic logic [15:0] capsWord(input logic coldWake);
        logic [15:0] w;
        w = 16'h0000;
        w[`PMC_BIT_WAKE_D3COLD] = coldWake;
        w[`PMC_BIT_WAKE_D3HOT] = 1'b1;
        w[`PMC_BIT_WAKE_D2] = funcX;
        w[`PMC_BIT_WAKE_D1] = 1'b1;
        w[`PMC_BIT_WAKE_D0] = funcX;
        w[`PMC_BIT_SECOND_SLEEP] = funcX;
        w[`PMC_BIT_FIRST_SLEEP] = 1'b1;
        // no cold wake means no standby draw to report
        w[`PMC_AUX_HI:`PMC_AUX_LO] = coldWake ? `PMC_AUX_CURRENT_100MA
            : `PMC_AUX_SELF_POWERED;
        w[`PMC_BIT_DEV_INIT] = 1'b0;
        w[`PMC_BIT_WAKE_CLOCK] = 1'b0;
        w[`PMC_REV_HI:`PMC_REV_LO] = `PMC_SPEC_REV_1_1;
        return w;
    endfunction : capsWord

    // ------------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------------
    pmc_phase_t phase;
    pmc_phase_t next_phase;
    logic [15:0] pmcWord;
    logic [15:0] next_pmcWord;

    always_comb
    begin
        next_phase = phase;
        next_pmcWord = pmcWord;
        unique case (phase)
            PMC_PH_STRAP:
            begin
                // strap taken at the first edge after reset release
                next_pmcWord = capsWord(coldWakeStrap);
                next_phase = PMC_PH_RUN;
            end
            PMC_PH_RUN:
            begin
                next_pmcWord = pmcWord;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase <= PMC_PH_STRAP;
            pmcWord <= 16'h0000;
        end
        else
        begin
            phase <= next_phase;
            pmcWord <= next_pmcWord;
        end
    end

    // ------------------------------------------------------------------------
    // configuration read decode
    // ------------------------------------------------------------------------
    function automatic logic [31:0] readDword(input logic [5:0] dw, input logic [15:0] caps);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (dw == ptrDword)
        begin
            d[7:0] = CAP_BASE;
        end
        else if (dw == baseDword)
        begin
            d[7:0] = `PMC_CAPABILITY_IDENTIFIER_VALUE;
            d[15:8] = `PMC_NEXT_VALUE;
            d[31:16] = caps;
        end
        else if (dw == ctrlDword)
        begin
            // control/status, bridge extension and data read as zero here
            d = 32'h0000_0000;
        end
        return d;
    endfunction : readDword

    // ------------------------------------------------------------------------
    // access answer
    // ------------------------------------------------------------------------
    logic done;
    logic next_done;
    logic [31:0] rdData;
    logic [31:0] next_rdData;
    logic take;

    assign take = (phase == PMC_PH_RUN) && (cfgReq.rd || cfgReq.wr);

    always_comb
    begin
        next_done = take;
        next_rdData = rdData;
        if (take && cfgReq.rd)
        begin
            next_rdData = readDword(cfgReq.dword, pmcWord);
        end
        else if (take)
        begin
            // write data is dropped; the answer carries zero
            next_rdData = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            done <= 1'b0;
            rdData <= 32'h0000_0000;
        end
        else
        begin
            done <= next_done;
            rdData <= next_rdData;
        end
    end

    assign cfgRsp.done = done;
    assign cfgRsp.rdData = rdData;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence readBase;
        phase == PMC_PH_RUN && cfgReq.rd && !cfgReq.wr && cfgReq.dword == baseDword;
    endsequence

    sequence readPtr;
        phase == PMC_PH_RUN && cfgReq.rd && !cfgReq.wr && cfgReq.dword == ptrDword;
    endsequence

    sequence readCtrl;
        phase == PMC_PH_RUN && cfgReq.rd && !cfgReq.wr && cfgReq.dword == ctrlDword;
    endsequence

    // any dword outside the pointer and the structure head
    sequence readOther;
        phase == PMC_PH_RUN && cfgReq.rd && !cfgReq.wr
            && cfgReq.dword != baseDword && cfgReq.dword != ptrDword;
    endsequence

    // read and write strobes together count as a read
    sequence readBoth;
        phase == PMC_PH_RUN && cfgReq.rd && cfgReq.wr && cfgReq.dword == baseDword;
    endsequence

    sequence writeAny;
        phase == PMC_PH_RUN && cfgReq.wr && !cfgReq.rd;
    endsequence

    sequence writeBase;
        phase == PMC_PH_RUN && cfgReq.wr && !cfgReq.rd && cfgReq.dword == baseDword;
    endsequence

    // a write into the structure, later followed by a read of it
    sequence writeThenRead;
        writeBase ##[1:8] readBase;
    endsequence

    sequence strapCycle;
        phase == PMC_PH_STRAP;
    endsequence

    // ------------------------------------------------------------------------
    // structure head and pointer
    // ------------------------------------------------------------------------
    chk_id_read: assert property (readBase |=> done && rdData[7:0] == 8'h01)
        else $error("identifier byte not 01h");

    chk_both_read: assert property (readBoth |=> done && rdData[15:0] == 16'h0001)
        else $error("combined strobes not answered as a read");

    chk_both_caps: assert property (readBoth |=> rdData[31:16] == pmcWord)
        else $error("combined strobes lost the capabilities word");

    chk_next_zero: assert property (readBase |=> rdData[15:8] == 8'h00)
        else $error("next offset not zero");

    chk_caps_read: assert property (readBase |=> rdData[31:16] == pmcWord)
        else $error("capabilities word mismatch");

    chk_wake_read: assert property (readBase |=> rdData[30] && rdData[28])
        else $error("wake support not seen on the bus");

    chk_rev_read: assert property (readBase |=> rdData[18:16] == 3'h2)
        else $error("revision not seen on the bus");

    chk_aux_read: assert property (
        readBase |=> rdData[24:22] == (rdData[31] ? 3'h2 : 3'h0))
        else $error("aux current not seen on the bus");

    chk_pointer_read: assert property (readPtr |=> rdData[7:0] == CAP_BASE)
        else $error("pointer does not lead to structure");

    chk_ptr_upper: assert property (readPtr |=> rdData[31:8] == 24'h00_0000)
        else $error("pointer dword carries stray bits");

    chk_ctrl_zero: assert property (readCtrl |=> done && rdData == 32'h0000_0000)
        else $error("control dword not zero");

    chk_other_no_id: assert property (readOther |=> rdData == 32'h0000_0000)
        else $error("second entry visible");

    // ------------------------------------------------------------------------
    // capabilities word contents
    // ------------------------------------------------------------------------
    chk_caps_stable: assert property (phase == PMC_PH_RUN |=> $stable(pmcWord))
        else $error("capabilities word changed");

    chk_wake_bits: assert property (
        phase == PMC_PH_RUN |-> pmcWord[14:11] == {1'b1, funcX, 1'b1, funcX})
        else $error("wake support bits wrong");

    chk_func_bits: assert property (
        phase == PMC_PH_RUN |-> {pmcWord[13], pmcWord[11], pmcWord[10]}
            == {3{FUNC_KIND == PMC_FUNC_EHCI}})
        else $error("flavour dependent bits wrong");

    chk_sleep_bits: assert property (phase == PMC_PH_RUN |-> pmcWord[10] == funcX)
        else $error("second sleep support bit wrong");

    chk_light_sleep: assert property (phase == PMC_PH_RUN |-> pmcWord[9] == 1'b1)
        else $error("first sleep support bit wrong");

    chk_fixed_low: assert property (
        phase == PMC_PH_RUN |-> pmcWord[5:3] == 3'h0 && pmcWord[2:0] == 3'h2)
        else $error("revision or reserved bits wrong");

    chk_aux_current: assert property (
        phase == PMC_PH_RUN |-> pmcWord[8:6] == (pmcWord[15] ? 3'h2 : 3'h0))
        else $error("aux current wrong");

    // ------------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------------
    // the strap is looked at once; later levels on the pin must not move bit 15
    chk_strap_take: assert property (
        strapCycle |=> phase == PMC_PH_RUN && pmcWord[15] == $past(coldWakeStrap))
        else $error("strap not captured");

    chk_strap_aux: assert property (
        strapCycle |=> pmcWord[8:6] == ($past(coldWakeStrap) ? 3'h2 : 3'h0))
        else $error("aux current does not follow strap");

    chk_strap_drop: assert property (strapCycle |=> !done)
        else $error("request answered during strap cycle");

    // ------------------------------------------------------------------------
    // access answers
    // ------------------------------------------------------------------------
    chk_write_ack: assert property (
        writeAny |=> done && rdData == 32'h0000_0000 ##1 $stable(pmcWord))
        else $error("write not completed cleanly");

    chk_write_no_effect: assert property (
        writeThenRead |=> rdData[15:0] == 16'h0001 && rdData[31:16] == pmcWord)
        else $error("write altered the structure");

    chk_ack_single: assert property (!take |=> !done)
        else $error("answer without request");

    chk_ack_every: assert property (take |=> done)
        else $error("request left unanswered");

    // read data stays put between answers so a late master still sees it
    chk_data_hold: assert property (!take |=> $stable(rdData))
        else $error("read data moved without request");

endmodule : pmc_capability

// ### test/pmc_capability_test.sv
module pmc_capability_test
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk;
    logic rst;
    logic strap [2];
    pmc_cfg_req_t req;
    pmc_cfg_rsp_t rsp [2];
    int miscompares;
    int nTests;

    // ------------------------------------------------------------------------
    // function 0 is the EHCI flavour, function 1 an OHCI one
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : fn
        pmc_capability #(
            .FUNC_KIND(pmc_func_kind_t'(g == 0)),
            .CAP_BASE(8'h40)
        ) pmc_capability_inst (
            .clk(clk),
            .rst(rst),
            .coldWakeStrap(strap[g]),
            .cfgReq(req),
            .cfgRsp(rsp[g])
        );
    end

    always #50 clk = ~clk;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] caps_word(input logic s, input logic x);
        return {s, 1'b1, x, 1'b1, x, x, 1'b1, (s ? 3'h2 : 3'h0), 3'h0, 3'h2};
    endfunction : caps_word

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out();
        if (miscompares == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic op(input logic r, input logic w, input logic [5:0] dw,
                      input logic [31:0] e0, input logic [31:0] e1);
        @(posedge clk);
        req <= '{rd: r, wr: w, dword: dw, byteEn: 4'hf, wrData: 32'hffffffff};
        @(posedge clk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        #1;
        chk({rsp[1].done, rsp[0].done}, 32'h3);
        chk(rsp[0].rdData, e0);
        chk(rsp[1].rdData, e1);
        @(posedge clk);
        #1;
        chk({rsp[1].done, rsp[0].done}, 32'h0);
    endtask : op

    // ------------------------------------------------------------------------
    // one pass with a given pair of strap levels
    // ------------------------------------------------------------------------
    task automatic scen(input logic s0, input logic s1);
        logic [31:0] c0;
        logic [31:0] c1;
        c0 = {caps_word(s0, 1'b1), 16'h0001};
        c1 = {caps_word(s1, 1'b0), 16'h0001};
        @(posedge clk);
        rst <= 1'b1;
        strap[0] <= s0;
        strap[1] <= s1;
        repeat (12) @(posedge clk);
        #1;
        chk(rsp[0].rdData | rsp[1].rdData, 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        req <= '{rd: 1'b1, wr: 1'b0, dword: 6'h10, byteEn: 4'hf, wrData: 32'h0};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk({rsp[1].done, rsp[0].done}, 32'h0);
        @(posedge clk);
        #1;
        chk({rsp[1].done, rsp[0].done}, 32'h0);
        op(1'b1, 1'b0, 6'h10, c0, c1);
        op(1'b1, 1'b0, 6'h0d, 32'h40, 32'h40);
        op(1'b1, 1'b0, 6'h11, 32'h0, 32'h0);
        op(1'b0, 1'b1, 6'h10, 32'h0, 32'h0);
        op(1'b0, 1'b1, 6'h0d, 32'h0, 32'h0);
        // the strap is read once; later levels must not reach bit 15
        @(posedge clk);
        strap[0] <= ~s0;
        strap[1] <= ~s1;
        op(1'b1, 1'b0, 6'h10, c0, c1);
        op(1'b1, 1'b1, 6'h10, c0, c1);
        // back-to-back reads, one per cycle
        @(posedge clk);
        req <= '{rd: 1'b1, wr: 1'b0, dword: 6'h10, byteEn: 4'hf, wrData: 32'h0};
        @(posedge clk);
        req.dword <= 6'h0d;
        #1;
        chk({rsp[0].rdData[31:16], rsp[1].rdData[31:16]}, {c0[31:16], c1[31:16]});
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk({rsp[1].done, rsp[0].done, rsp[0].rdData[7:0]}, {2'b11, 8'h40});
        // no other dword carries the identifier or anything else
        for (int d = 0; d < 64; d++)
        begin
            if (d != 'h10 && d != 'h0d)
                op(1'b1, 1'b0, d[5:0], 32'h0, 32'h0);
        end
    endtask : scen

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        strap[0] = 1'b1;
        strap[1] = 1'b0;
        req = '0;
        miscompares = 0;
        nTests = 0;
        scen(1'b1, 1'b0);
        scen(1'b0, 1'b1);
        close_out();
    end

endmodule : pmc_capability_test
